// ---- rtl/usbcb_top.sv ----
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module usbcb_top #(
  parameter logic [16:0] sof_cyc = 17'(usbcb_pkg::sof_cycles)
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link engine side
  input wire logic sof_rx,
  input wire logic [10:0] sof_rx_frame,
  input wire logic token_done,
  output logic module_on,
  output logic pingpong_pointer_reset,
  output logic [15:0] pp_odd,
  output logic host_logic_reset,
  output logic sof_tx,
  output logic resume_drive,
  output logic ls_eop_drive,
  output logic [3:0] token_command,
  output logic token_start
);
  // ****************************************
  // register bus
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [10:0] frame_ff;
  logic tokbusy_ff;
  logic [7:0] tok_ff;
  logic pp_toggle;
  logic wr;
  logic rd_hit;
  logic host_ff;
  logic [1:0] rsm_prev_ff;
  usbcb_pkg::usbcb_rsm_type rsm_ff;
  usbcb_pkg::usbcb_rsm_type nxt_rsm;
  logic [9:0] eop_cnt_ff;
  logic sof_done;

  assign pready = 1'b1;
  assign wr = psel && penable && pwrite;
  assign rd_hit = (paddr == usbcb_pkg::ctrl_addr) || (paddr == usbcb_pkg::tok_addr)
    || (paddr == usbcb_pkg::frame_number_low_addr) || (paddr == usbcb_pkg::frmh_addr)
    || (paddr == usbcb_pkg::stat_addr);
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= usbcb_pkg::zero_word;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        usbcb_pkg::ctrl_addr: prdata <= ctrl_ff | (32'(tokbusy_ff) << usbcb_pkg::bit_tokbusy);
        usbcb_pkg::tok_addr: prdata <= {24'h000000, tok_ff};
        usbcb_pkg::frame_number_low_addr: prdata <= {24'h000000, frame_ff[usbcb_pkg::frame_number_low_w-1:0]};
        usbcb_pkg::frmh_addr: prdata <= {29'h00000000, frame_ff[usbcb_pkg::frm_w-1:usbcb_pkg::frame_number_low_w]};
        usbcb_pkg::stat_addr: prdata <= {15'h0000, 1'b0, pp_odd};
        default: prdata <= usbcb_pkg::zero_word;
      endcase
    end
  end

  // control register; ping-pong reset bit is a self-clearing strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= usbcb_pkg::ctrl_reset;
    else if (wr && paddr == usbcb_pkg::ctrl_addr)
      ctrl_ff <= pwdata & usbcb_pkg::ctrl_wmask & ~(32'h1 << usbcb_pkg::bit_ppreset);
  end

  assign pingpong_pointer_reset = wr && paddr == usbcb_pkg::ctrl_addr && pwdata[usbcb_pkg::bit_ppreset]; // RQ1
  assign module_on = ctrl_ff[usbcb_pkg::bit_enable]; // RQ2
  assign host_ff = ctrl_ff[usbcb_pkg::bit_hostmode];

  // ****************************************
  // token command; busy shows until engine done
  // ****************************************
  // a write while busy is dropped, guarding against software that skips the check
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tok_ff <= 8'h00;
      tokbusy_ff <= 1'b0;
    end
    else if (host_logic_reset)
      tokbusy_ff <= 1'b0; // RQ5
    else if (wr && paddr == usbcb_pkg::tok_addr && !tokbusy_ff) // RQ4
    begin
      tok_ff <= pwdata[7:0];
      tokbusy_ff <= 1'b1;
    end
    else if (token_done)
      tokbusy_ff <= 1'b0;
  end
  assign token_start = wr && paddr == usbcb_pkg::tok_addr && !tokbusy_ff && !host_logic_reset;
  assign token_command = tok_ff[7:4];

  // ****************************************
  // ping-pong pointers
  // ****************************************
  assign pp_toggle = token_done && module_on;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pp_odd <= 16'h0000;
    else if (pingpong_pointer_reset)
      pp_odd <= 16'h0000; // RQ1
    else if (pp_toggle)
      pp_odd[tok_ff[3:0]] <= ~pp_odd[tok_ff[3:0]];
  end

  // ****************************************
  // host logic reset on host bit toggle
  // ****************************************
  logic host_prev_ff;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      host_prev_ff <= 1'b0;
    else
      host_prev_ff <= host_ff;
  end
  assign host_logic_reset = host_prev_ff != host_ff; // RQ5

  // ****************************************
  // frame marker generation
  // ****************************************
  usbcb_counter #(.width(17), .limit(sof_cyc)) u_sof (
    .pclk(pclk),
    .presetn(presetn),
    .clr(host_logic_reset),
    .run(host_ff && ctrl_ff[usbcb_pkg::bit_frame_marker_enable]),
    .done(sof_done)
  );
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sof_tx <= 1'b0;
    else
      sof_tx <= sof_done; // RQ3
  end

  // ****************************************
  // frame number capture
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_ff <= 11'h000;
    else if (sof_rx)
      frame_ff <= sof_rx_frame; // RQ8
  end

  // ****************************************
  // resume signalling
  // ****************************************
  always_comb
  begin
    nxt_rsm = rsm_ff;
    unique case (rsm_ff)
      usbcb_pkg::usbcb_idle_type_s:
        if (ctrl_ff[usbcb_pkg::bit_resume])
          nxt_rsm = usbcb_pkg::usbcb_rsm_type_s;
      usbcb_pkg::usbcb_rsm_type_s:
        if (!ctrl_ff[usbcb_pkg::bit_resume])
          nxt_rsm = host_ff ? usbcb_pkg::usbcb_eop_type_s : usbcb_pkg::usbcb_idle_type_s; // RQ7
      usbcb_pkg::usbcb_eop_type_s:
        if (eop_cnt_ff == 10'(usbcb_pkg::eop_cycles - 1))
          nxt_rsm = usbcb_pkg::usbcb_idle_type_s;
      default: nxt_rsm = usbcb_pkg::usbcb_idle_type_s;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsm_ff <= usbcb_pkg::usbcb_idle_type_s;
    else
      rsm_ff <= nxt_rsm;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      eop_cnt_ff <= 10'h000;
    else if (rsm_ff == usbcb_pkg::usbcb_eop_type_s)
      eop_cnt_ff <= eop_cnt_ff + 10'h001;
    else
      eop_cnt_ff <= 10'h000;
  end
  // resume length is timed by software, the block only follows the bit
  assign resume_drive = rsm_ff == usbcb_pkg::usbcb_rsm_type_s; // RQ6
  assign ls_eop_drive = rsm_ff == usbcb_pkg::usbcb_eop_type_s;

  // ****************************************
  // checks
  // ****************************************
  a_pp_reset_clear: assert property (@(posedge pclk) disable iff (!presetn)
    pingpong_pointer_reset |=> pp_odd == 16'h0000) else $error("pointers not back to even"); // RQ1
  a_enable_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == usbcb_pkg::ctrl_addr) |=> module_on == $past(pwdata[usbcb_pkg::bit_enable]))
    else $error("enable wrong"); // RQ2
  a_sof_off: assert property (@(posedge pclk) disable iff (!presetn)
    !(host_ff && ctrl_ff[usbcb_pkg::bit_frame_marker_enable]) [*2] |-> !sof_tx) else $error("sof while disabled"); // RQ3
  a_tok_guard: assert property (@(posedge pclk) disable iff (!presetn)
    tokbusy_ff && !token_done && !host_logic_reset |=> tokbusy_ff && $stable(tok_ff)) else $error("busy lost"); // RQ4
  a_host_reset: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(host_ff) |-> host_logic_reset ##1 (!tokbusy_ff && !sof_tx)) else $error("no host reset"); // RQ5
  a_resume_follow: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(ctrl_ff[usbcb_pkg::bit_resume]) |=> resume_drive) else $error("resume not driven"); // RQ6
  a_eop_host: assert property (@(posedge pclk) disable iff (!presetn)
    resume_drive && !ctrl_ff[usbcb_pkg::bit_resume] && host_ff |=> ls_eop_drive [*3]) else $error("no eop"); // RQ7
  a_frame_load: assert property (@(posedge pclk) disable iff (!presetn)
    sof_rx |=> frame_ff == $past(sof_rx_frame)) else $error("frame not loaded"); // RQ8
endmodule

// ---- rtl/usbcb_pkg.sv ----
// Behaviour
// (RQ1) ping-pong reset returns pointers to even bank
// (RQ2) module enable switches function-mode logic on/off
// (RQ3) host mode: frame marker sent every 1 ms
// (RQ4) software waits for token idle before command
// (RQ5) host-bit toggle resets all host control logic; code clears only token busy and frame marker timer, not resume state
// (RQ6) software holds resume 10 ms function, 25 ms host
// (RQ7) host resume clear appends low-speed end-of-packet
// (RQ8) received frame marker loads 11-bit frame number
package usbcb_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] tok_addr = 8'h04;
  localparam logic [7:0] frame_number_low_addr = 8'h08;
  localparam logic [7:0] frmh_addr = 8'h0c;
  localparam logic [7:0] stat_addr = 8'h10;
  // ****************************************
  // control fields
  // ****************************************
  localparam int bit_enable = 0;
  localparam int bit_ppreset = 1;
  localparam int bit_resume = 2;
  localparam int bit_hostmode = 3;
  localparam int bit_tokbusy = 5;
  localparam int bit_frame_marker_enable = 6;
  localparam logic [31:0] ctrl_wmask = 32'h0000004f;
  localparam logic [31:0] ctrl_reset = 32'h00000000;
  localparam logic [31:0] zero_word = 32'h00000000;
  localparam int num_ep = 16;
  localparam int frm_w = 11;
  localparam int frame_number_low_w = 8;
  localparam logic [10:0] frm_one = 11'h001;
  // ****************************************
  // timing
  // ****************************************
  localparam int clk_mhz = 100;
  localparam int sof_period_us = 1000;
  localparam int sof_cycles = sof_period_us * clk_mhz;
  localparam int eop_ns = 1330;
  localparam int eop_cycles = (eop_ns * clk_mhz + 999) / 1000;
  typedef enum logic [1:0] {
    usbcb_idle_type_s = 2'b00,
    usbcb_rsm_type_s = 2'b01,
    usbcb_eop_type_s = 2'b11
  } usbcb_rsm_type;
endpackage

// ---- rtl/usbcb_counter.sv ----
`timescale 1ns/10ps
module usbcb_counter #(
  parameter int width = 17,
  parameter logic [16:0] limit = 17'h00001
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic clr,
  input wire logic run,
  // status
  output logic done
);
  logic [width-1:0] cnt_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_ff <= '0;
    else if (clr || !run || done)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + width'(1);
  end

  assign done = run && !clr && (cnt_ff == width'(limit - 17'h00001));
endmodule

// ---- tb/usbcb_link_model.sv ----
`timescale 1ns/10ps
module usbcb_link_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic slow,
  input wire logic sof_req,
  input wire logic [10:0] frame_val,
  // link engine side
  input wire logic token_start,
  output logic sof_rx,
  output logic [10:0] sof_rx_frame,
  output logic token_done
);
  int cnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      token_done <= 1'b0;
      sof_rx <= 1'b0;
      sof_rx_frame <= 11'h000;
    end
    else
    begin
      token_done <= (cnt == 1);
      if (token_start)
        cnt <= slow ? 40 : 3;
      else if (cnt != 0)
        cnt <= cnt - 1;
      sof_rx <= sof_req;
      // frame lines are not held between markers
      sof_rx_frame <= sof_req ? frame_val : ~sof_rx_frame;
    end
  end
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, sof_req = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sof_rx, token_done, module_on, pp_rst, host_rst, sof_tx, rsm, eop, token_start;
  logic [10:0] frame_val = 11'h5a3;
  logic [10:0] sof_rx_frame;
  logic [15:0] pp_odd;
  logic [3:0] token_command;
  int n_errors = 0, checks = 0, n_hr = 0, n_sof = 0, n_eop = 0, n_ts = 0, n_pp = 0, base;
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    n_hr <= n_hr + int'(host_rst);
    n_sof <= n_sof + int'(sof_tx);
    n_eop <= n_eop + int'(eop);
    n_ts <= n_ts + int'(token_start);
    n_pp <= n_pp + int'(pp_rst);
  end
  usbcb_top #(.sof_cyc(17'h00014)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sof_rx(sof_rx), .sof_rx_frame(sof_rx_frame), .token_done(token_done), .module_on(module_on),
    .pingpong_pointer_reset(pp_rst), .pp_odd(pp_odd), .host_logic_reset(host_rst), .sof_tx(sof_tx),
    .resume_drive(rsm), .ls_eop_drive(eop), .token_command(token_command), .token_start(token_start));
  usbcb_link_model u_link (.pclk(pclk), .presetn(presetn), .slow(slow), .sof_req(sof_req),
    .frame_val(frame_val), .token_start(token_start), .sof_rx(sof_rx), .sof_rx_frame(sof_rx_frame),
    .token_done(token_done));
  task tally_and_finish;
    if (n_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  // software must see the token engine idle before a new command
  task wait_idle;
    int k;
    k = 0;
    do
    begin
      apb(1'b0, 8'h00, 32'h0);
      k++;
    end
    while (rd[usbcb_pkg::bit_tokbusy] !== 1'b0 && k < 100);
    if (rd[usbcb_pkg::bit_tokbusy] !== 1'b0)
    begin
      n_errors++;
      tally_and_finish;
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask
  initial
  begin
    wait_n(20);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    `CHK("frame_number_low", 32'h0, rd)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 33'h100000000, {err, rd})
    apb(1'b1, 8'h00, 32'h1);
    wait_n(2);
    `CHK("module_on", 1'b1, module_on)
    wait_idle;
    apb(1'b1, 8'h04, 32'h93);
    wait_idle;
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'ha5);
    apb(1'b1, 8'h04, 32'h17);
    wait_n(1);
    `CHK("tok_refused", 4'ha, token_command)
    apb(1'b0, 8'h04, 32'h0);
    `CHK("tok_reg", 32'ha5, rd)
    wait_idle;
    `CHK("pp_odd", 16'h0028, pp_odd)
    `CHK("tok_starts", 2, n_ts)
    apb(1'b1, 8'h00, 32'h1);
    wait_n(2);
    `CHK("pp_keep", 16'h0028, pp_odd)
    apb(1'b1, 8'h00, 32'h3);
    wait_n(2);
    `CHK("pp_strobe", 1, n_pp)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("pp_reset", 32'h0, rd)
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl_rb", 32'h1, rd)
    apb(1'b1, 8'h00, 32'h0);
    wait_n(2);
    `CHK("module_off", 1'b0, module_on)
    // a finished token must not move a pointer while the module is off
    wait_idle;
    apb(1'b1, 8'h04, 32'h01);
    wait_idle;
    apb(1'b0, 8'h10, 32'h0);
    `CHK("pp_off", 32'h0, rd)
    sof_req <= 1'b1;
    wait_n(1);
    sof_req <= 1'b0;
    wait_n(3);
    apb(1'b0, 8'h08, 32'h0);
    `CHK("frame_number_low", 32'ha3, rd)
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("frmh", 32'h5, rd)
    base = n_hr;
    apb(1'b1, 8'h00, 32'h08);
    apb(1'b1, 8'h00, 32'h48);
    wait_n(3);
    `CHK("host_rst", base + 1, n_hr)
    base = n_sof;
    wait_n(100);
    `CHK("sof_on", base + 5, n_sof)
    apb(1'b1, 8'h00, 32'h08);
    wait_n(2);
    base = n_sof;
    wait_n(100);
    `CHK("sof_off", base, n_sof)
    apb(1'b1, 8'h00, 32'h0c);
    wait_n(2);
    `CHK("resume", 1'b1, rsm)
    wait_n(50);
    base = n_eop;
    apb(1'b1, 8'h00, 32'h08);
    wait_n(200);
    `CHK("ls_eop", base + 133, n_eop)
    base = n_hr;
    apb(1'b1, 8'h00, 32'h00);
    wait_n(3);
    `CHK("host_rst_off", base + 1, n_hr)
    // function mode: resume ends without a low-speed end-of-packet
    base = n_eop;
    apb(1'b1, 8'h00, 32'h04);
    wait_n(2);
    `CHK("resume_fn", 1'b1, rsm)
    apb(1'b1, 8'h00, 32'h00);
    wait_n(3);
    `CHK("resume_end", 1'b0, rsm)
    `CHK("no_eop_fn", base, n_eop)
    tally_and_finish;
  end
endmodule
